/* parallel_port_status_pins_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module parallel_port_status_pins_tb;
    import ppsp_pkg::*;
    logic clk, arst_n, psel, penable, pwrite, wakeup, pslverr, pready, sp0, sp1, err_v;
    logic [31:0] paddr, pwdata, prdata, rd_v;
    logic [15:0] pin_in, pin_out, pin_oe, ext, sstate, sword;
    int error_cnt = 0;
    int num_checks = 0;
    ppsp_top ppsp_top_inst (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .multiplexed_port_pin_in(pin_in), .multiplexed_port_pin_out(pin_out),
        .multiplexed_port_pin_oe(pin_oe), .wakeup(wakeup), .speakerphone_state(sstate),
        .status_word(sword), .status_pin_zero(sp0), .status_pin_one(sp1));
    ppsp_periph ppsp_periph_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext),
        .pin_level(pin_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            test_done();
        end
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Status pin model from integers
    function automatic int sps_exp(int mode, int pos, int sp, int st, int sw);
        if (mode == 1) return sp;
        if (mode == 4) return (st >> pos) & 3;
        if (mode == 6) return (sw >> pos) & 3;
        return 0;
    endfunction
    initial begin
        logic [31:0] v, m, d;
        int k, ist, isw;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        wakeup = 1'b0;
        ext = 16'h0;
        sstate = 16'h0;
        sword = 16'h0;
        void'($urandom(32'h7017));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, IDX_PORT_OUT_SLOT0 + 8'(k), 32'hFFFF);
            apb(1'b0, IDX_PORT_OUT_SLOT0 + 8'(k), 32'h0);
            chk("slot readback", rd_v, 32'h0FFF);
        end
        apb(1'b0, 8'h00, 32'h0);
        chk("unmapped error", {31'h0, err_v}, 32'h1);
        chk("unmapped data", rd_v, 32'h0);
        $display("test registers done");
        v = $urandom & 32'hFFFF;
        m = $urandom & 32'hFFFF;
        d = $urandom & 32'hFFFF;
        apb(1'b1, IDX_PORT_OUT_SLOT3_STATIC, v);
        apb(1'b1, IDX_PORT_WAY_MASK, m);
        apb(1'b1, IDX_PORT_CONFIG, {30'h0, CFG_STATIC});
        ext <= d[15:0];
        repeat (3) @(posedge clk);
        chk("static oe", {16'h0, pin_oe}, m);
        chk("static out", {16'h0, pin_out & pin_oe}, v & m);
        apb(1'b0, IDX_PORT_INPUT_WORD, 32'h0);
        chk("static in", rd_v, (v & m) | (d & ~m & 32'hFFFF));
        $display("test static done");
        apb(1'b1, IDX_PORT_CONFIG, {30'h0, CFG_TIMESLOT});
        for (k = 1; k < 4; k++) begin
            v = $urandom & 32'hFFFF;
            apb(1'b1, IDX_PORT_OUT_SLOT0 + 8'(k), v);
            ext <= 16'h1000 << k;
            repeat (3) @(posedge clk);
            chk("slot out", {20'h0, pin_out[11:0]}, v & 32'hFFF);
            chk("slot oe", {16'h0, pin_oe}, 32'hFFF);
        end
        apb(1'b1, IDX_PORT_OUT_SLOT0, v);
        ext <= {4'h1, d[11:0]};
        repeat (3) @(posedge clk);
        chk("strobe oe", {20'h0, pin_oe[11:0]}, m & 32'hFFF);
        chk("strobe out", {20'h0, pin_out[11:0] & pin_oe[11:0]}, v & m & 32'hFFF);
        apb(1'b1, IDX_PORT_WAY_MASK, 32'h0);
        ext <= {4'h0, d[11:0]};
        repeat (3) @(posedge clk);
        apb(1'b0, IDX_PORT_INPUT_WORD, 32'h0);
        chk("captured in", rd_v & 32'hFFF, d & 32'hFFF);
        $display("test timeslot done");
        ist = $urandom & 32'hFFFF;
        isw = $urandom & 32'hFFFF;
        sstate <= 16'(ist);
        sword <= 16'(isw);
        for (k = 0; k < 16; k++) begin
            m = ($urandom & 32'hF003) | 32'(k % 8) << 2;
            apb(1'b1, IDX_STATUS_PIN_CONTROL, m);
            repeat (2) @(posedge clk);
            d = 32'(sps_exp(k % 8, int'(m[15:12]), int'(m[1:0]), ist, isw));
            chk("status pins", {30'h0, sp1, sp0}, d);
        end
        for (k = 0; k < 2; k++) begin
            v = 32'hE001 | 32'(k ? 1 : 6) << 2;
            wakeup <= 1'b1;
            apb(1'b1, IDX_STATUS_PIN_CONTROL, v);
            wakeup <= 1'b0;
            @(posedge clk);
            apb(1'b0, IDX_STATUS_PIN_CONTROL, 32'h0);
            chk("wakeup mode", rd_v, k ? v : v & ~32'h1C);
        end
        $display("test status pins done");
        test_done();
    end
endmodule
`default_nettype wire

/* ppsp_periph.sv */
`timescale 1ns/1ps
`default_nettype none
// Peripheral on the port pins: drives every pin the device leaves as input
module ppsp_periph (
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] ext_drive,
    output logic [15:0] pin_level
);
    always_comb begin
        pin_level = (pin_out & pin_oe) | (ext_drive & ~pin_oe);
    end
endmodule
`default_nettype wire

/* ppsp_pkg.sv */
package ppsp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS_PIN_CONTROL = 8'h47;
    localparam logic [7:0] IDX_PORT_OUT_SLOT0 = 8'h4A;
    localparam logic [7:0] IDX_PORT_OUT_SLOT1 = 8'h4B;
    localparam logic [7:0] IDX_PORT_OUT_SLOT2 = 8'h4C;
    localparam logic [7:0] IDX_PORT_OUT_SLOT3_STATIC = 8'h4D;
    localparam logic [7:0] IDX_PORT_INPUT_WORD = 8'h4E;
    localparam logic [7:0] IDX_PORT_WAY_MASK = 8'h4F;
    localparam logic [7:0] IDX_PORT_CONFIG = 8'h50;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] RST_CONFIG = 2'h0;
    localparam logic [1:0] CFG_TIMESLOT = 2'h2;
    localparam logic [1:0] CFG_STATIC = 2'h1;
    localparam logic [2:0] SPS_OFF = 3'h0;
    localparam logic [2:0] SPS_DIRECT = 3'h1;
    localparam logic [2:0] SPS_STATE = 3'h4;
    localparam logic [2:0] SPS_STATUS = 3'h6;
    localparam int MODE_LSB = 2;
    localparam int POS_LSB = 12;
    localparam int STROBE0 = 12;
    localparam int SLOT_BITS = 12;
endpackage

/* ppsp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ppsp_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] multiplexed_port_pin_in,
    output logic [15:0] multiplexed_port_pin_out,
    output logic [15:0] multiplexed_port_pin_oe,
    input wire logic wakeup,
    input wire logic [15:0] speakerphone_state,
    input wire logic [15:0] status_word,
    output logic status_pin_zero,
    output logic status_pin_one
);
    import ppsp_pkg::*;

    logic [15:0] ctl_ff, nxt_ctl;
    logic [15:0] slot_ff [4];
    logic [15:0] nxt_slot [4];
    logic [15:0] din_ff, nxt_din;
    logic [15:0] mask_ff, nxt_mask;
    logic [1:0] cfg_ff, nxt_cfg;
    logic strb_ff, nxt_strb;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [15:0] pout_ff, nxt_pout;
    logic [15:0] poe_ff, nxt_poe;
    logic status_pin_zero_ff, nxt_status_pin_zero;
    logic status_pin_one_ff, nxt_status_pin_one;
    logic setup, wr, hit;
    logic [7:0] idx;
    logic [15:0] src;
    logic [16:0] src_ext;
    logic [4:0] pos;

    assign setup = psel && !penable;
    assign idx = paddr[9:2];
    assign hit = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0) &&
        ((idx == IDX_STATUS_PIN_CONTROL) || (idx >= IDX_PORT_OUT_SLOT0 && idx <= IDX_PORT_CONFIG));
    assign wr = psel && penable && pready_ff && pwrite && !pslverr_ff;

    // Registers and bus answer
    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_mask = mask_ff;
        nxt_cfg = cfg_ff;
        for (int i = 0; i < 4; i++) begin
            nxt_slot[i] = slot_ff[i];
        end
        nxt_pready = setup;
        nxt_pslverr = setup && !hit;
        nxt_prdata = 32'h0;
        if (setup && hit && !pwrite) begin
            case (idx)
                IDX_STATUS_PIN_CONTROL: nxt_prdata = {16'h0, ctl_ff};
                IDX_PORT_OUT_SLOT0: nxt_prdata = {16'h0, slot_ff[0]};
                IDX_PORT_OUT_SLOT1: nxt_prdata = {16'h0, slot_ff[1]};
                IDX_PORT_OUT_SLOT2: nxt_prdata = {16'h0, slot_ff[2]};
                IDX_PORT_OUT_SLOT3_STATIC: nxt_prdata = {16'h0, slot_ff[3]};
                IDX_PORT_INPUT_WORD: nxt_prdata = {16'h0, din_ff};
                IDX_PORT_WAY_MASK: nxt_prdata = {16'h0, mask_ff};
                IDX_PORT_CONFIG: nxt_prdata = {30'h0, cfg_ff};
                default: nxt_prdata = 32'h0;
            endcase
        end
        if (wr) begin
            case (idx)
                IDX_STATUS_PIN_CONTROL: nxt_ctl = pwdata[15:0];
                // Upper nibble of slots 0-2 is not stored
                IDX_PORT_OUT_SLOT0: nxt_slot[0] = {4'h0, pwdata[11:0]};
                IDX_PORT_OUT_SLOT1: nxt_slot[1] = {4'h0, pwdata[11:0]};
                IDX_PORT_OUT_SLOT2: nxt_slot[2] = {4'h0, pwdata[11:0]};
                IDX_PORT_OUT_SLOT3_STATIC: nxt_slot[3] = pwdata[15:0];
                IDX_PORT_WAY_MASK: nxt_mask = pwdata[15:0];
                IDX_PORT_CONFIG: nxt_cfg = pwdata[1:0];
                default: nxt_cfg = cfg_ff;
            endcase
        end
        // Wakeup wins over a write in the same cycle unless the written mode is SPS_DIRECT
        if (wakeup && nxt_ctl[MODE_LSB +: 3] != SPS_DIRECT) begin
            nxt_ctl[MODE_LSB +: 3] = SPS_OFF;
        end
    end

    // Port pins
    always_comb begin
        nxt_pout = 16'h0;
        nxt_poe = 16'h0;
        nxt_din = din_ff;
        nxt_strb = multiplexed_port_pin_in[STROBE0];
        if (cfg_ff == CFG_TIMESLOT) begin
            // Strobes are inputs; data pins carry the active slot
            for (int i = 0; i < 4; i++) begin
                if (multiplexed_port_pin_in[STROBE0 + i]) begin
                    nxt_pout = {4'h0, slot_ff[i][SLOT_BITS-1:0]};
                end
            end
            if (multiplexed_port_pin_in[STROBE0]) begin
                nxt_poe = {4'h0, mask_ff[SLOT_BITS-1:0]};
            end else if (|multiplexed_port_pin_in[15:13]) begin
                nxt_poe = 16'h0FFF;
            end
            if (strb_ff && !multiplexed_port_pin_in[STROBE0]) begin
                nxt_din = {4'h0, multiplexed_port_pin_in[SLOT_BITS-1:0]};
            end
        end else if (cfg_ff == CFG_STATIC) begin
            nxt_pout = slot_ff[3];
            nxt_poe = mask_ff;
            nxt_din = multiplexed_port_pin_in;
        end
    end

    // Status pins
    always_comb begin
        case (ctl_ff[MODE_LSB +: 3])
            SPS_STATE: src = speakerphone_state;
            SPS_STATUS: src = status_word;
            default: src = 16'h0;
        endcase
        src_ext = {1'b0, src};
        pos = {1'b0, ctl_ff[POS_LSB +: 4]};
        case (ctl_ff[MODE_LSB +: 3])
            SPS_DIRECT: begin
                nxt_status_pin_zero = ctl_ff[0];
                nxt_status_pin_one = ctl_ff[1];
            end
            SPS_STATE, SPS_STATUS: begin
                nxt_status_pin_zero = src_ext[pos];
                nxt_status_pin_one = src_ext[pos + 5'h1];
            end
            default: begin
                nxt_status_pin_zero = 1'b0;
                nxt_status_pin_one = 1'b0;
            end
        endcase
    end

    // Register group
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_ff <= RST_WORD;
            for (int i = 0; i < 4; i++) begin
                slot_ff[i] <= RST_WORD;
            end
            mask_ff <= RST_WORD;
            cfg_ff <= RST_CONFIG;
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            for (int i = 0; i < 4; i++) begin
                slot_ff[i] <= nxt_slot[i];
            end
            mask_ff <= nxt_mask;
            cfg_ff <= nxt_cfg;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Port pin group
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            din_ff <= RST_WORD;
            strb_ff <= 1'b0;
            pout_ff <= RST_WORD;
            poe_ff <= RST_WORD;
        end else begin
            din_ff <= nxt_din;
            strb_ff <= nxt_strb;
            pout_ff <= nxt_pout;
            poe_ff <= nxt_poe;
        end
    end

    // Status pin group
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_pin_zero_ff <= 1'b0;
            status_pin_one_ff <= 1'b0;
        end else begin
            status_pin_zero_ff <= nxt_status_pin_zero;
            status_pin_one_ff <= nxt_status_pin_one;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign multiplexed_port_pin_out = pout_ff;
    assign multiplexed_port_pin_oe = poe_ff;
    assign status_pin_zero = status_pin_zero_ff;
    assign status_pin_one = status_pin_one_ff;

    AST_TS_DRIVE: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && multiplexed_port_pin_in[15:12] == 4'h2)
        |=> multiplexed_port_pin_out == {4'h0, $past(slot_ff[1][11:0])})
        else $error("timeslot one word not driven");
    AST_STATIC_DRIVE: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_STATIC) |=> multiplexed_port_pin_out == $past(slot_ff[3]))
        else $error("static word not driven");
    AST_TS_CAPTURE: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && strb_ff && !multiplexed_port_pin_in[STROBE0])
        |=> din_ff == {4'h0, $past(multiplexed_port_pin_in[11:0])})
        else $error("strobe fall capture missed");
    AST_STATIC_IN: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_STATIC) |=> din_ff == $past(multiplexed_port_pin_in))
        else $error("static input not sampled");
    AST_MASK: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_STATIC) |=> multiplexed_port_pin_oe == $past(mask_ff))
        else $error("direction mask not applied");
    AST_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == SPS_OFF) |=> !status_pin_zero && !status_pin_one)
        else $error("disabled status pins not low");
    AST_WINDOW: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == SPS_STATUS && ctl_ff[15:12] == 4'hE)
        |=> status_pin_zero == $past(status_word[14]) && status_pin_one == $past(status_word[15]))
        else $error("status window wrong");
    AST_WAKE: assert property (@(posedge clk) disable iff (!arst_n)
        (wakeup && ctl_ff[4:2] != SPS_DIRECT && !wr) |=> ctl_ff[4:2] == SPS_OFF)
        else $error("wakeup did not clear mode");
    AST_DIRECT: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == SPS_DIRECT) |=> status_pin_one == $past(ctl_ff[1])
        && status_pin_zero == $past(ctl_ff[0]))
        else $error("direct control not followed");
    AST_RESERVED: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == 3'h7) |=> !status_pin_zero && !status_pin_one)
        else $error("reserved mode drove pins");
    AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
        slot_ff[0][15:12] == 4'h0 && slot_ff[1][15:12] == 4'h0
        && slot_ff[2][15:12] == 4'h0)
        else $error("unused slot bits set");
    AST_TS_SLOT0: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && multiplexed_port_pin_in[15:12] == 4'h1)
        |=> multiplexed_port_pin_out == {4'h0, $past(slot_ff[0][11:0])})
        else $error("timeslot zero word not driven");
    AST_TS_SLOT2: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && multiplexed_port_pin_in[15:12] == 4'h4)
        |=> multiplexed_port_pin_out == {4'h0, $past(slot_ff[2][11:0])})
        else $error("timeslot two word not driven");
    AST_TS_SLOT3: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && multiplexed_port_pin_in[15:12] == 4'h8)
        |=> multiplexed_port_pin_out == {4'h0, $past(slot_ff[3][11:0])})
        else $error("timeslot three word not driven");
    AST_TS_STROBE_IN: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT)
        |=> multiplexed_port_pin_oe[15:12] == 4'h0)
        else $error("strobe pins driven in timeslot mode");
    AST_TS_DATA_OE: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && !multiplexed_port_pin_in[STROBE0]
        && multiplexed_port_pin_in[15:13] != 3'h0)
        |=> multiplexed_port_pin_oe == 16'h0FFF)
        else $error("data pins not driven in output slot");
    AST_TS_UPPER_OUT: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT)
        |=> multiplexed_port_pin_out[15:12] == 4'h0)
        else $error("strobe pin levels set in timeslot mode");
    AST_TS_MASK: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && multiplexed_port_pin_in[STROBE0])
        |=> multiplexed_port_pin_oe == {4'h0, $past(mask_ff[11:0])})
        else $error("direction mask not applied in slot zero");
    AST_TS_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && multiplexed_port_pin_in[15:12] == 4'h0)
        |=> multiplexed_port_pin_oe == 16'h0)
        else $error("pins driven with no strobe");
    AST_PORT_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff != CFG_TIMESLOT && cfg_ff != CFG_STATIC)
        |=> multiplexed_port_pin_oe == 16'h0 && multiplexed_port_pin_out == 16'h0)
        else $error("port driven while off");
    AST_TS_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_ff == CFG_TIMESLOT && !(strb_ff && !multiplexed_port_pin_in[STROBE0]))
        |=> din_ff == $past(din_ff))
        else $error("input word changed without strobe fall");
    AST_SLOT3_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && idx == IDX_PORT_OUT_SLOT3_STATIC)
        |=> slot_ff[3] == $past(pwdata[15:0]))
        else $error("static word not stored in full");
    AST_RESERVED2: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == 3'h2)
        |=> !status_pin_zero && !status_pin_one)
        else $error("reserved mode two drove pins");
    AST_RESERVED3: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == 3'h3)
        |=> !status_pin_zero && !status_pin_one)
        else $error("reserved mode three drove pins");
    AST_RESERVED5: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == 3'h5)
        |=> !status_pin_zero && !status_pin_one)
        else $error("reserved mode five drove pins");
    AST_STATE_WIN: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == SPS_STATE)
        |=> status_pin_zero == $past(speakerphone_state[ctl_ff[15:12]]))
        else $error("state window low bit wrong");
    AST_STATE_WIN_ONE: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == SPS_STATE && ctl_ff[15:12] != 4'hF)
        |=> status_pin_one == $past(speakerphone_state[ctl_ff[15:12] + 4'h1]))
        else $error("state window high bit wrong");
    AST_STATUS_WIN: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == SPS_STATUS)
        |=> status_pin_zero == $past(status_word[ctl_ff[15:12]]))
        else $error("status window low bit wrong");
    AST_STATUS_WIN_ONE: assert property (@(posedge clk) disable iff (!arst_n)
        (ctl_ff[4:2] == SPS_STATUS && ctl_ff[15:12] != 4'hF)
        |=> status_pin_one == $past(status_word[ctl_ff[15:12] + 4'h1]))
        else $error("status window high bit wrong");
    AST_WAKE_KEEP: assert property (@(posedge clk) disable iff (!arst_n)
        (wakeup && ctl_ff[4:2] == SPS_DIRECT && !wr)
        |=> ctl_ff[4:2] == SPS_DIRECT)
        else $error("wakeup changed direct mode");
    AST_WAKE_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
        (wakeup && wr && idx == IDX_STATUS_PIN_CONTROL && pwdata[4:2] != SPS_DIRECT)
        |=> ctl_ff[4:2] == SPS_OFF)
        else $error("wakeup lost to mode write");
    AST_MODE_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && idx == IDX_STATUS_PIN_CONTROL && !wakeup)
        |=> ctl_ff == $past(pwdata[15:0]))
        else $error("status pin control not stored");
    AST_SLOT_READ: assert property (@(posedge clk) disable iff (!arst_n)
        (setup && hit && !pwrite && idx == IDX_PORT_OUT_SLOT0)
        |=> prdata[15:12] == 4'h0)
        else $error("unused slot bits read back");
    AST_SLOT_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && idx == IDX_PORT_OUT_SLOT1)
        |=> slot_ff[1] == {4'h0, $past(pwdata[11:0])})
        else $error("slot one word not stored");
endmodule
`default_nettype wire
